// [design/mrl_cell_group.sv]
// One group of programmable logic cells with routing, expanders and registers
// How it works
// - every cell owns five local product terms from the array
// - each local term goes to OR sum, clear, preset, clock, enable or aux
// - shareable expanders are inverted single terms fed back into the array
// - a cell may borrow a neighbour's terms through the parallel chain
// - local plus borrowed terms never exceed 32 for one cell
// - sixteen cells per group; expanders stay inside the group
// - each register works as D, T, JK or SR flipflop
// - bypass makes the cell output the plain combinational result
// - global clock mode updates on every rising global clock edge
// - enabled global mode updates only with the enable term high
// - array clock mode clocks on a product term edge
// - each global clock is true or inverted level of either pin
// - clear and preset terms act at once, active high
// - the low global clear pin can clear selected registers
// - all registers start low after power-up
// - a fast path feeds an I/O pin straight to register input
// - dedicated pins, I/O pins and cell outputs all drive the routing matrix
// - each routed signal enters the group through an enable AND
// - every routing path has the same one-cycle delay
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
module mrl_cell_group
  import mrl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  // Register bus
  input  wire mrl_apb_req_type       apb_req,
  output mrl_apb_rsp_type            apb_rsp,
  // Device pins
  input  wire logic [DED_PINS-1:0]   ded_pin,
  input  wire logic [IO_PINS-1:0]    io_pin,
  input  wire logic                  global_clock_pin_a,
  input  wire logic                  global_clock_pin_b,
  input  wire logic                  global_clear_pin_n,
  // Cell outputs
  output logic [CELLS-1:0]           cell_out
);

  // Configuration storage
  mrl_gcfg_type                  gcfg_q;
  logic [NSRC-1:0]               route_en_q;
  logic [CELL_IDX_W-1:0]         cell_idx_q;
  logic [TERM_IDX_W-1:0]         term_idx_q;
  mrl_cell_cfg_type              cell_cfg_q [CELLS];
  logic [NLIT-1:0]               term_t_q   [NTERM];
  logic [NLIT-1:0]               term_c_q   [NTERM];

  // Pins and routing
  logic [PIN_W-1:0]              pin_meta_q;
  logic [PIN_W-1:0]              pin_sync_q;
  logic [DED_PINS-1:0]           ded_s;
  logic [IO_PINS-1:0]            io_s;
  logic                          gclk_a_s;
  logic                          gclk_b_s;
  logic                          gclr_n_s;
  logic [NSRC-1:0]               route_q;
  logic [NSRC-1:0]               grp_in;
  logic [CELLS-1:0]              exp_vec;
  logic [NLIT-1:0]               lits;

  // Clocking and cell state
  logic [1:0]                    gsig;
  logic [1:0]                    gsig_q;
  logic [1:0]                    gedge;
  logic [CELLS-1:0]              aclk_q;
  logic [CELLS-1:0]              ff_q;
  logic [CELLS-1:0]              ff_d;
  logic [CELLS-1:0]              cell_out_q;
  logic [CELLS-1:0]              or_vec;
  logic [CELLS-1:0]              clr_pt;
  logic [CELLS-1:0]              pre_pt;
  logic [CELLS-1:0]              clk_pt;
  logic [CELLS-1:0]              ena_pt;
  logic [CELLS-1:0]              aux_pt;
  logic [CELLS-1:0]              sum_vec;
  logic [CELLS-1:0]              f_vec;
  logic [CELLS-1:0]              din_vec;
  logic [CELLS-1:0]              clr_vec;
  logic [CELLS-1:0]              pre_vec;
  logic [CELLS-1:0]              tick_vec;

  // Bus slave
  mrl_apb_state_type             apb_state_q;
  mrl_apb_rsp_type               apb_rsp_q;
  logic [DATA_W-1:0]             rd_data;
  logic                          rd_hit;
  logic                          wr_ok;
  logic                          term_ok;

  // An empty term (no literal selected) reads as unprogrammed and stays low
  function automatic logic pterm(input logic [NLIT-1:0] tm, input logic [NLIT-1:0] cm,
                                 input logic [NLIT-1:0] lv);
    pterm = ((tm | cm) != '0) && ((lv & tm) == tm) && ((~lv & cm) == cm);
  endfunction : pterm

  function automatic logic next_ff(input mrl_ff_type ff, input logic q, input logic d,
                                   input logic aux);
    case (ff)
      FF_D:    next_ff = d;
      FF_T:    next_ff = d ^ q;
      FF_JK:   next_ff = (d & ~q) | (~aux & q);
      // Both set and reset high holds the state
      FF_SR:   next_ff = (d & ~aux) | (q & ~(aux & ~d));
      default: next_ff = q;
    endcase
  endfunction : next_ff

  // Pin synchroniser; only the second stage is read
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= {global_clear_pin_n, global_clock_pin_b, global_clock_pin_a, io_pin, ded_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign ded_s    = pin_sync_q[DED_PINS-1:0];
  assign io_s     = pin_sync_q[DED_PINS +: IO_PINS];
  assign gclk_a_s = pin_sync_q[PIN_W-3];
  assign gclk_b_s = pin_sync_q[PIN_W-2];
  assign gclr_n_s = pin_sync_q[PIN_W-1];

  // single routing stage
  // Every source passes one flop, so all routed signals share the same latency
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      route_q <= '0;
    else
      route_q <= {cell_out_q, io_s, ded_s};
  end

  assign grp_in = route_q & route_en_q;

  always_comb
  begin
    for (int c = 0; c < CELLS; c++)
      exp_vec[c] = ~pterm(term_t_q[EXP_BASE+c] & SRC_ONLY, term_c_q[EXP_BASE+c] & SRC_ONLY,
                          {{CELLS{1'b0}}, grp_in});
  end

  assign lits = {exp_vec, grp_in};

  assign gsig[0] = (gcfg_q.g0_pin_b ? gclk_b_s : gclk_a_s) ^ gcfg_q.g0_inv;
  assign gsig[1] = (gcfg_q.g1_pin_b ? gclk_b_s : gclk_a_s) ^ gcfg_q.g1_inv;
  assign gedge   = gsig & ~gsig_q;

  always_comb
  begin
    logic pt;
    pt     = 1'b0;
    or_vec = '0;
    clr_pt = '0;
    pre_pt = '0;
    clk_pt = '0;
    ena_pt = '0;
    aux_pt = '0;
    for (int c = 0; c < CELLS; c++)
    begin
      for (int k = 0; k < LOCAL_TERMS; k++)
      begin
        pt = pterm(term_t_q[c*LOCAL_TERMS+k], term_c_q[c*LOCAL_TERMS+k], lits);
        case (cell_cfg_q[c].route[k])
          RT_OR:   or_vec[c] = or_vec[c] | pt;
          RT_CLR:  clr_pt[c] = clr_pt[c] | pt;
          RT_PRE:  pre_pt[c] = pre_pt[c] | pt;
          RT_CLK:  clk_pt[c] = clk_pt[c] | pt;
          RT_ENA:  ena_pt[c] = ena_pt[c] | pt;
          RT_AUX:  aux_pt[c] = aux_pt[c] | pt;
          default: ;
        endcase
      end
    end
  end

  // parallel expander chain
  // A lending cell gives up its own sum; links past the term ceiling are dropped
  always_comb
  begin
    logic               chain;
    logic               borrowed;
    logic [DEPTH_W-1:0] depth;
    chain    = 1'b0;
    borrowed = 1'b0;
    depth    = '0;
    for (int c = 0; c < CELLS; c++)
    begin
      borrowed = cell_cfg_q[c].borrow && (depth != '0) &&
                 (depth <= DEPTH_W'(PAR_LINKS_MAX)) && chain;
      if (cell_cfg_q[c].lend)
      begin
        sum_vec[c] = 1'b0;
        chain      = or_vec[c] | borrowed;
        depth      = (cell_cfg_q[c].borrow && depth != '0) ? depth + DEPTH_W'(1) : DEPTH_W'(1);
      end
      else
      begin
        sum_vec[c] = or_vec[c] | borrowed;
        chain      = 1'b0;
        depth      = '0;
      end
    end
  end

  // Register next state for every cell
  always_comb
  begin
    for (int c = 0; c < CELLS; c++)
    begin
      f_vec[c] = sum_vec[c] ^ cell_cfg_q[c].xor_inv;
      if (cell_cfg_q[c].fast_en && (cell_cfg_q[c].fast_idx < 3'(IO_PINS)))
        din_vec[c] = io_s[cell_cfg_q[c].fast_idx];
      else
        din_vec[c] = f_vec[c];
      clr_vec[c] = clr_pt[c] | (cell_cfg_q[c].gclr_en & ~gclr_n_s);
      pre_vec[c] = pre_pt[c];
      case (cell_cfg_q[c].clk_mode)
        CLK_GLOBAL:     tick_vec[c] = gedge[cell_cfg_q[c].gclk_sel];
        CLK_GLOBAL_ENA: tick_vec[c] = gedge[cell_cfg_q[c].gclk_sel] & ena_pt[c];
        CLK_ARRAY:      tick_vec[c] = clk_pt[c] & ~aclk_q[c];
        default:        tick_vec[c] = 1'b0;
      endcase
      // clear wins over preset, both over the clock
      if (clr_vec[c])
        ff_d[c] = 1'b0;
      else if (pre_vec[c])
        ff_d[c] = 1'b1;
      else if (tick_vec[c])
        ff_d[c] = next_ff(cell_cfg_q[c].ff, ff_q[c], din_vec[c], aux_pt[c]);
      else
        ff_d[c] = ff_q[c];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ff_q   <= '0;
      aclk_q <= '0;
      gsig_q <= '0;
    end
    else
    begin
      ff_q   <= ff_d;
      aclk_q <= clk_pt;
      gsig_q <= gsig;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cell_out_q <= '0;
    else
    begin
      for (int c = 0; c < CELLS; c++)
        cell_out_q[c] <= cell_cfg_q[c].bypass ? f_vec[c] : ff_d[c];
    end
  end

  assign cell_out = cell_out_q;

  // Bus read decode
  assign term_ok = (term_idx_q < TERM_IDX_W'(NTERM));

  always_comb
  begin
    rd_data = '0;
    rd_hit  = 1'b1;
    case (apb_req.paddr)
      OFS_GLOBAL_CFG: rd_data = gcfg_q;
      OFS_ROUTE_EN:   rd_data = DATA_W'(route_en_q);
      OFS_CELL_IDX:   rd_data = DATA_W'(cell_idx_q);
      OFS_CELL_CFG:   rd_data = cell_cfg_q[cell_idx_q];
      OFS_TERM_IDX:   rd_data = DATA_W'(term_idx_q);
      OFS_TRUE_LO:    rd_data = term_ok ? term_t_q[term_idx_q][DATA_W-1:0] : '0;
      OFS_TRUE_HI:    rd_data = term_ok ? DATA_W'(term_t_q[term_idx_q][NLIT-1:DATA_W]) : '0;
      OFS_COMP_LO:    rd_data = term_ok ? term_c_q[term_idx_q][DATA_W-1:0] : '0;
      OFS_COMP_HI:    rd_data = term_ok ? DATA_W'(term_c_q[term_idx_q][NLIT-1:DATA_W]) : '0;
      OFS_CELL_STATE: rd_data = DATA_W'(cell_out_q);
      OFS_PIN_STATE:  rd_data = DATA_W'(pin_sync_q);
      default:        rd_hit  = 1'b0;
    endcase
  end

  // One wait state so that the answer leaves from flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      apb_state_q <= AP_IDLE;
      apb_rsp_q   <= APB_RSP_RST;
    end
    else
    begin
      case (apb_state_q)
        AP_IDLE:
        begin
          if (apb_req.psel && apb_req.penable)
          begin
            apb_state_q       <= AP_REPLY;
            apb_rsp_q.pready  <= 1'b1;
            apb_rsp_q.pslverr <= ~rd_hit;
            apb_rsp_q.prdata  <= apb_req.pwrite ? '0 : rd_data;
          end
        end
        AP_REPLY:
        begin
          apb_state_q <= AP_IDLE;
          apb_rsp_q   <= APB_RSP_RST;
        end
        default:
        begin
          apb_state_q <= AP_IDLE;
          apb_rsp_q   <= APB_RSP_RST;
        end
      endcase
    end
  end

  assign apb_rsp = apb_rsp_q;
  assign wr_ok   = (apb_state_q == AP_REPLY) && apb_req.psel && apb_req.penable &&
                   apb_req.pwrite;

  // Global and index registers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gcfg_q     <= GCFG_RST;
      route_en_q <= '0;
      cell_idx_q <= '0;
      term_idx_q <= '0;
    end
    else if (wr_ok)
    begin
      case (apb_req.paddr)
        OFS_GLOBAL_CFG: gcfg_q     <= mrl_gcfg_type'(apb_req.pwdata);
        OFS_ROUTE_EN:   route_en_q <= apb_req.pwdata[NSRC-1:0];
        OFS_CELL_IDX:   cell_idx_q <= apb_req.pwdata[CELL_IDX_W-1:0];
        OFS_TERM_IDX:   term_idx_q <= apb_req.pwdata[TERM_IDX_W-1:0];
        default: ;
      endcase
    end
  end

  // Cell configuration, reached through the cell index
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int c = 0; c < CELLS; c++)
        cell_cfg_q[c] <= CELL_CFG_RST;
    end
    else if (wr_ok && apb_req.paddr == OFS_CELL_CFG)
      cell_cfg_q[cell_idx_q] <= mrl_cell_cfg_type'(apb_req.pwdata);
  end

  // Term literal masks, reached through the term index
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int t = 0; t < NTERM; t++)
      begin
        term_t_q[t] <= '0;
        term_c_q[t] <= '0;
      end
    end
    else if (wr_ok && term_ok)
    begin
      case (apb_req.paddr)
        OFS_TRUE_LO: term_t_q[term_idx_q][DATA_W-1:0]    <= apb_req.pwdata;
        OFS_TRUE_HI: term_t_q[term_idx_q][NLIT-1:DATA_W] <= apb_req.pwdata[LIT_HI_W-1:0];
        OFS_COMP_LO: term_c_q[term_idx_q][DATA_W-1:0]    <= apb_req.pwdata;
        OFS_COMP_HI: term_c_q[term_idx_q][NLIT-1:DATA_W] <= apb_req.pwdata[LIT_HI_W-1:0];
        default: ;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  logic [CELLS-1:0] hold_ena_vec;
  logic [CELLS-1:0] glob_vec;
  logic [CELLS-1:0] byp_vec;
  logic [CELLS-1:0] gclr_vec;

  always_comb
  begin
    for (int c = 0; c < CELLS; c++)
    begin
      hold_ena_vec[c] = (cell_cfg_q[c].clk_mode == CLK_GLOBAL_ENA) && !ena_pt[c] &&
                        !clr_vec[c] && !pre_vec[c];
      glob_vec[c]     = (cell_cfg_q[c].clk_mode == CLK_GLOBAL) && !clr_vec[c] &&
                        !pre_vec[c] && (cell_cfg_q[c].ff == FF_D);
      byp_vec[c]      = cell_cfg_q[c].bypass;
      gclr_vec[c]     = cell_cfg_q[c].gclr_en;
    end
  end

  a_clear_forces_low: assert property (|clr_vec |=> ((ff_q & $past(clr_vec)) == '0))
    else $error("cleared register not low");
  a_preset_forces_high: assert property (|(pre_vec & ~clr_vec) |=>
    ((ff_q & $past(pre_vec & ~clr_vec)) == $past(pre_vec & ~clr_vec)))
    else $error("preset register not high");
  a_global_clear_pin: assert property (!gclr_n_s && |gclr_vec |=>
    ((ff_q & $past(gclr_vec)) == '0))
    else $error("global clear pin ignored");
  a_enable_low_hold: assert property (|hold_ena_vec |=>
    ((ff_q & $past(hold_ena_vec)) == ($past(ff_q) & $past(hold_ena_vec))))
    else $error("register changed without enable");
  a_global_d_load: assert property (|glob_vec |=>
    ((ff_q & $past(glob_vec)) ==
     ($past(glob_vec) & (($past(din_vec) & $past(tick_vec)) | ($past(ff_q) & ~$past(tick_vec))))))
    else $error("global D register wrong");
  a_bypass_output: assert property (|byp_vec |=>
    ((cell_out & $past(byp_vec)) == ($past(f_vec) & $past(byp_vec))))
    else $error("bypassed cell not combinational");
  a_route_latency: assert property (##1 route_q[NSRC-1 -: CELLS] == $past(cell_out_q, 1))
    else $error("routed cell output delay wrong");
  // Compares the gated group input with the sources one cycle back
  a_route_gate: assert property (grp_in ==
    ($past({cell_out_q, io_s, ded_s}) & route_en_q))
    else $error("unselected signal entered group");
  a_global_edge_seen: assert property ($rose(gsig[0]) |-> gedge[0])
    else $error("global edge missed");
  a_bus_reply: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready |=>
    apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("bus reply not one cycle");

  c_global_edge: cover property (|(tick_vec & glob_vec));
  c_array_clock: cover property (|(tick_vec & clk_pt));
  c_bus_write:   cover property (wr_ok);

endmodule : mrl_cell_group

// [design/mrl_pkg.sv]
// Shared constants and types for the programmable logic cell group
package mrl_pkg;

  // Group geometry
  localparam int CELLS         = 16;
  localparam int LOCAL_TERMS   = 5;
  localparam int SUM_TERMS_MAX = 32;
  localparam int DED_PINS      = 2;
  localparam int IO_PINS       = 6;
  localparam int NSRC          = DED_PINS + IO_PINS + CELLS;
  localparam int NLIT          = NSRC + CELLS;
  localparam int EXP_BASE      = CELLS * LOCAL_TERMS;
  localparam int NTERM         = EXP_BASE + CELLS;
  localparam int PAR_LINKS_MAX = SUM_TERMS_MAX / LOCAL_TERMS - 1;
  localparam int PIN_W         = DED_PINS + IO_PINS + 3;
  localparam int CELL_IDX_W    = $clog2(CELLS);
  localparam int TERM_IDX_W    = $clog2(NTERM);
  localparam int DEPTH_W       = 5;

  // Bus geometry
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int LIT_HI_W = NLIT - DATA_W;

  // Expander terms see routed signals only, never other expanders
  localparam logic [NLIT-1:0] SRC_ONLY = {{CELLS{1'b0}}, {NSRC{1'b1}}};

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ROUTE_EN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CELL_IDX   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CELL_CFG   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TERM_IDX   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TRUE_LO    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TRUE_HI    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COMP_LO    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_COMP_HI    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CELL_STATE = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE  = 8'h28;

  typedef enum logic [1:0] {
    FF_D  = 2'h0,
    FF_T  = 2'h1,
    FF_JK = 2'h2,
    FF_SR = 2'h3
  } mrl_ff_type;

  typedef enum logic [1:0] {
    CLK_GLOBAL     = 2'h0,
    CLK_GLOBAL_ENA = 2'h1,
    CLK_ARRAY      = 2'h2
  } mrl_clk_mode_type;

  typedef enum logic [2:0] {
    RT_OR  = 3'h0,
    RT_CLR = 3'h1,
    RT_PRE = 3'h2,
    RT_CLK = 3'h3,
    RT_ENA = 3'h4,
    RT_AUX = 3'h5
  } mrl_route_type;

  typedef enum logic [1:0] {
    AP_IDLE  = 2'h0,
    AP_REPLY = 2'h1
  } mrl_apb_state_type;

  typedef struct packed {
    logic [2:0]                         spare;
    mrl_route_type [LOCAL_TERMS-1:0]    route;
    logic                               borrow;
    logic                               lend;
    logic [2:0]                         fast_idx;
    logic                               fast_en;
    logic                               gclr_en;
    logic                               xor_inv;
    logic                               gclk_sel;
    mrl_clk_mode_type                   clk_mode;
    logic                               bypass;
    mrl_ff_type                         ff;
  } mrl_cell_cfg_type;

  typedef struct packed {
    logic [27:0] spare;
    logic        g1_inv;
    logic        g1_pin_b;
    logic        g0_inv;
    logic        g0_pin_b;
  } mrl_gcfg_type;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } mrl_apb_req_type;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } mrl_apb_rsp_type;

  // Reset values
  localparam mrl_gcfg_type     GCFG_RST     = 32'h0000_0000;
  localparam mrl_cell_cfg_type CELL_CFG_RST = 32'h0000_0000;
  localparam mrl_apb_rsp_type  APB_RSP_RST  = '0;

endpackage : mrl_pkg

// [verification/testbench.sv]
// Self-checking bench for the logic cell group
`timescale 1ns/1ns
module testbench;
  import mrl_pkg::*;

  logic               clk_sys;
  logic               rst_b;
  mrl_apb_req_type    req;
  mrl_apb_rsp_type    rsp;
  logic [IO_PINS-1:0] io;
  logic [DED_PINS-1:0] ded;
  logic               clk_a;
  logic               clk_b;
  logic               clr_n;
  logic [CELLS-1:0]   cell_out;
  mrl_cell_cfg_type   cfg;
  logic [31:0]        rd;
  logic               err;
  int                 err_total;
  int                 n_compared;

  mrl_cell_group mrl_cell_group_i (
    .clk_sys            (clk_sys),
    .rst_b              (rst_b),
    .apb_req            (req),
    .apb_rsp            (rsp),
    .ded_pin            (ded),
    .io_pin             (io),
    .global_clock_pin_a (clk_a),
    .global_clock_pin_b (clk_b),
    .global_clear_pin_n (clr_n),
    .cell_out           (cell_out)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      $display("[ERR] %0t bus answer missing", $time);
      err_total++;
      complete_run();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic term(input logic [6:0] idx, input logic [31:0] lo);
    apb(1'b1, OFS_TERM_IDX, {25'h0, idx});
    apb(1'b1, OFS_TRUE_LO, lo);
  endtask : term

  task automatic pulse(input logic use_b);
    @(posedge clk_sys);
    if (use_b)
      clk_b <= 1'b1;
    else
      clk_a <= 1'b1;
    cyc(4);
    clk_a <= 1'b0;
    clk_b <= 1'b0;
    cyc(6);
  endtask : pulse

  task automatic clear_pin();
    @(posedge clk_sys);
    clr_n <= 1'b0;
    cyc(4);
    clr_n <= 1'b1;
    cyc(4);
  endtask : clear_pin

  task automatic t_reset();
    chk(cell_out, 0);
    apb(1'b0, OFS_CELL_CFG, 32'h0);
    chk(rd, CELL_CFG_RST);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask : t_reset

  // Term 0 of cell 0 is dedicated pin 0 and io pin 0 (routed bits 0 and 2)
  task automatic t_comb();
    apb(1'b1, OFS_ROUTE_EN, 32'h00FF_FFFF);
    term(7'h00, 32'h0000_0005);
    cfg = CELL_CFG_RST;
    cfg.bypass = 1'b1;
    apb(1'b1, OFS_CELL_CFG, cfg);
    io[0] <= 1'b1;
    cyc(8);
    chk(cell_out[0], 0);
    ded[0] <= 1'b1;
    cyc(8);
    chk(cell_out[0], 1);
    apb(1'b1, OFS_ROUTE_EN, 32'h0);
    cyc(8);
    chk(cell_out[0], 0);
    apb(1'b1, OFS_ROUTE_EN, 32'h00FF_FFFF);
    $display("combinational test done");
  endtask : t_comb

  task automatic t_dff();
    cfg = CELL_CFG_RST;
    cfg.gclr_en = 1'b1;
    apb(1'b1, OFS_CELL_CFG, cfg);
    cyc(8);
    chk(cell_out[0], 0);
    pulse(1'b0);
    chk(cell_out[0], 1);
    cfg.clk_mode = CLK_GLOBAL_ENA;
    apb(1'b1, OFS_CELL_CFG, cfg);
    io[0] <= 1'b0;
    pulse(1'b0);
    chk(cell_out[0], 1);
    clear_pin();
    chk(cell_out[0], 0);
    $display("flipflop test done");
  endtask : t_dff

  // Term input is low; only the fast path can load a one
  task automatic t_fast();
    cfg = CELL_CFG_RST;
    cfg.gclr_en = 1'b1;
    cfg.fast_en = 1'b1;
    cfg.fast_idx = 3'h1;
    apb(1'b1, OFS_CELL_CFG, cfg);
    io[1] <= 1'b1;
    pulse(1'b0);
    chk(cell_out[0], 1);
    clear_pin();
    io[1] <= 1'b0;
    $display("fast path test done");
  endtask : t_fast

  task automatic t_clk_sel();
    cfg = CELL_CFG_RST;
    cfg.gclr_en = 1'b1;
    apb(1'b1, OFS_CELL_CFG, cfg);
    apb(1'b1, OFS_GLOBAL_CFG, 32'h1);
    io[0] <= 1'b1;
    pulse(1'b0);
    chk(cell_out[0], 0);
    pulse(1'b1);
    chk(cell_out[0], 1);
    io[0] <= 1'b0;
    clear_pin();
    $display("clock select test done");
  endtask : t_clk_sel

  // Term 1 on io pin 1 drives preset; the register never clocks
  task automatic t_preset();
    term(7'h01, 32'h0000_0008);
    cfg = CELL_CFG_RST;
    cfg.clk_mode = mrl_clk_mode_type'(2'h3);
    cfg.route[1] = RT_PRE;
    apb(1'b1, OFS_CELL_CFG, cfg);
    cyc(8);
    chk(cell_out[0], 0);
    io[1] <= 1'b1;
    cyc(8);
    chk(cell_out[0], 1);
    $display("preset test done");
  endtask : t_preset

  // Cell 1 toggles as T flipflop on rising edges of a clock term on io pin 0
  task automatic t_array();
    apb(1'b1, OFS_CELL_IDX, 32'h1);
    term(7'h05, 32'h0000_0004);
    cfg = CELL_CFG_RST;
    cfg.ff = FF_T;
    cfg.xor_inv = 1'b1;
    cfg.clk_mode = CLK_ARRAY;
    cfg.route[0] = RT_CLK;
    apb(1'b1, OFS_CELL_CFG, cfg);
    cyc(8);
    chk(cell_out[1], 0);
    io[0] <= 1'b1;
    cyc(8);
    chk(cell_out[1], 1);
    io[0] <= 1'b0;
    cyc(8);
    chk(cell_out[1], 1);
    io[0] <= 1'b1;
    cyc(8);
    chk(cell_out[1], 0);
    io[0] <= 1'b0;
    $display("array clock test done");
  endtask : t_array

  // Cell 3 sums its own term on cell 2's expander (not io pin 1) and cell 2's lent io pin 0
  task automatic t_expand();
    term(7'h52, 32'h0000_0008);
    term(7'h0A, 32'h0000_0004);
    term(7'h0F, 32'h0400_0000);
    cfg = CELL_CFG_RST;
    cfg.lend = 1'b1;
    apb(1'b1, OFS_CELL_IDX, 32'h2);
    apb(1'b1, OFS_CELL_CFG, cfg);
    cfg.lend = 1'b0;
    cfg.borrow = 1'b1;
    cfg.bypass = 1'b1;
    apb(1'b1, OFS_CELL_IDX, 32'h3);
    apb(1'b1, OFS_CELL_CFG, cfg);
    io[1] <= 1'b1;
    io[0] <= 1'b0;
    cyc(8);
    chk(cell_out[3], 0);
    io[1] <= 1'b0;
    cyc(8);
    chk(cell_out[3], 1);
    io[1] <= 1'b1;
    io[0] <= 1'b1;
    cyc(8);
    chk(cell_out[3], 1);
    $display("expander test done");
  endtask : t_expand

  initial
  begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    req = '0;
    io = '0;
    ded = '0;
    clk_a = 1'b0;
    clk_b = 1'b0;
    clr_n = 1'b1;
    err_total = 0;
    n_compared = 0;
    cyc(8);
    rst_b <= 1'b1;
    t_reset();
    t_comb();
    t_dff();
    t_fast();
    t_clk_sel();
    t_preset();
    t_array();
    t_expand();
    complete_run();
  end
endmodule : testbench
